// [urs_defines.svh]
// register offsets, field positions and reset values of the register select
`ifndef URS_DEFINES_SVH
`define URS_DEFINES_SVH

`define URS_ADDR_W         3
`define URS_DATA_W         8
`define URS_ICR_COUNT      4

`define URS_ADDR_DATA      3'h0
`define URS_ADDR_IER       3'h1
`define URS_ADDR_FIFO      3'h2
`define URS_ADDR_FORMAT    3'h3
`define URS_ADDR_MODEM     3'h4
`define URS_ADDR_LSTATE    3'h5
`define URS_ADDR_MSTATE    3'h6
`define URS_ADDR_SCRATCH   3'h7

`define URS_FMT_DLAB_BIT   7
`define URS_COMPAT_KEY     8'hbf
`define URS_ACR_EXT_BIT    7
`define URS_ACR_IDX_BIT    6
`define URS_ICR_ACR_IDX    8'h00

`define URS_RST_BYTE       8'h00
`define URS_RST_FORMAT     8'h00
`define URS_RST_DIV_LOW    8'h00
`define URS_RST_DIV_HIGH   8'h00

`endif

// [urs_pkg.sv]
// types shared by the register select and its address decoder
`include "urs_defines.svh"
package urs_pkg;

  typedef enum logic [4:0] {
    URS_SEL_NONE    = 5'h00,
    URS_SEL_XMIT    = 5'h01,
    URS_SEL_RECV    = 5'h02,
    URS_SEL_DIV_LO  = 5'h03,
    URS_SEL_DIV_HI  = 5'h04,
    URS_SEL_IER     = 5'h05,
    URS_SEL_FIFO    = 5'h06,
    URS_SEL_IDENT   = 5'h07,
    URS_SEL_FORMAT  = 5'h08,
    URS_SEL_MODEM   = 5'h09,
    URS_SEL_LSTATE  = 5'h0a,
    URS_SEL_MSTATE  = 5'h0b,
    URS_SEL_SCRATCH = 5'h0c,
    URS_SEL_FLOW    = 5'h0d,
    URS_SEL_XON1    = 5'h0e,
    URS_SEL_XON2    = 5'h0f,
    URS_SEL_XOFF1   = 5'h10,
    URS_SEL_XOFF2   = 5'h11,
    URS_SEL_EXTSTAT = 5'h12,
    URS_SEL_RXLVL   = 5'h13,
    URS_SEL_TXLVL   = 5'h14,
    URS_SEL_INDEX   = 5'h15
  } urs_sel_t;

  typedef struct packed {
    logic [7:0]                         fmt;
    logic                               compat;
    logic [7:0]                         div_lo;
    logic [7:0]                         div_hi;
    logic [7:0]                         interrupt_enable;
    logic [7:0]                         fifo;
    logic [7:0]                         modem;
    logic [7:0]                         scratch;
    logic [7:0]                         flow;
    logic [3:0][7:0]                    xchar;
    logic [`URS_ICR_COUNT-1:0][7:0]     indexed_control_set;
    logic [7:0]                         rdata;
    logic                               rx_pop;
    logic                               tx_load;
    logic [7:0]                         tx_data;
  } urs_state_t;

endpackage

// [urs_decode.sv]
// address decoder: picks the read and write target from address and modes
module urs_decode
  import urs_pkg::*;
(
  // address and mode state
  input  wire logic [2:0] addr,
  input  wire logic       dlab,
  input  wire logic       compat,
  input  wire logic       ext_en,
  input  wire logic       idx_rd_en,
  // selections
  output urs_sel_t        rd_sel,
  output urs_sel_t        wr_sel
);

  // the compatibility view needs dlab set, so it is checked first
  always_comb
  begin
    rd_sel = URS_SEL_NONE;
    wr_sel = URS_SEL_NONE;
    case (addr)
      `URS_ADDR_DATA:
      begin
        rd_sel = dlab ? URS_SEL_DIV_LO : URS_SEL_RECV;
        wr_sel = dlab ? URS_SEL_DIV_LO : URS_SEL_XMIT;
      end
      `URS_ADDR_IER:
      begin
        rd_sel = dlab ? URS_SEL_DIV_HI
               : (ext_en ? URS_SEL_EXTSTAT : URS_SEL_IER);
        wr_sel = dlab ? URS_SEL_DIV_HI
               : (ext_en ? URS_SEL_NONE : URS_SEL_IER);
      end
      `URS_ADDR_FIFO:
      begin
        rd_sel = compat ? URS_SEL_FLOW : URS_SEL_IDENT;
        wr_sel = compat ? URS_SEL_FLOW : URS_SEL_FIFO;
      end
      `URS_ADDR_FORMAT:
      begin
        rd_sel = (ext_en && !compat) ? URS_SEL_RXLVL : URS_SEL_FORMAT;
        wr_sel = URS_SEL_FORMAT;
      end
      `URS_ADDR_MODEM:
      begin
        rd_sel = compat ? URS_SEL_XON1
               : (ext_en ? URS_SEL_TXLVL : URS_SEL_MODEM);
        wr_sel = compat ? URS_SEL_XON1 : URS_SEL_MODEM;
      end
      `URS_ADDR_LSTATE:
      begin
        rd_sel = compat ? URS_SEL_XON2
               : (idx_rd_en ? URS_SEL_INDEX : URS_SEL_LSTATE);
        wr_sel = compat ? URS_SEL_XON2 : URS_SEL_INDEX;
      end
      `URS_ADDR_MSTATE:
      begin
        rd_sel = compat ? URS_SEL_XOFF1 : URS_SEL_MSTATE;
        wr_sel = compat ? URS_SEL_XOFF1 : URS_SEL_NONE;
      end
      `URS_ADDR_SCRATCH:
      begin
        rd_sel = compat ? URS_SEL_XOFF2 : URS_SEL_SCRATCH;
        wr_sel = compat ? URS_SEL_XOFF2 : URS_SEL_SCRATCH;
      end
      default:
      begin
        rd_sel = URS_SEL_NONE;
        wr_sel = URS_SEL_NONE;
      end
    endcase
  end

endmodule

// [urs_top.sv]
// register select of the enhanced uart: bank overlay and register storage
module urs_top
  import urs_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // host register port
  input  wire logic [2:0]  addr,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata_q,
  // receive and transmit data path
  input  wire logic [7:0]  rx_data,
  output logic             rx_pop_q,
  output logic             tx_load_q,
  output logic      [7:0]  tx_data_q,
  // status from the serial core
  input  wire logic [7:0]  ident_in,
  input  wire logic [7:0]  line_state_in,
  input  wire logic [7:0]  modem_state_in,
  input  wire logic [7:0]  ext_status_in,
  input  wire logic [7:0]  rx_level_in,
  input  wire logic [7:0]  tx_level_in,
  // settings to the serial core
  output logic      [15:0] divisor_q,
  output logic      [6:0]  frame_format_q,
  output logic             tx_break_q,
  output logic      [7:0]  interrupt_enable_q,
  output logic      [7:0]  fifo_control_q,
  output logic      [7:0]  modem_control_q,
  output logic      [7:0]  flow_control_q,
  output logic      [7:0]  additional_control_q
);

  urs_state_t st_q;
  urs_state_t st_d;
  urs_sel_t   rd_sel;
  urs_sel_t   wr_sel;
  logic       wr_go;
  logic       rd_go;

  // a write and a read in one cycle: the write is taken, the read dropped
  assign wr_go = wr_en;
  assign rd_go = rd_en && !wr_en;

  urs_decode u_decode (
    .addr      (addr),
    .dlab      (st_q.fmt[`URS_FMT_DLAB_BIT]),
    .compat    (st_q.compat),
    .ext_en    (st_q.indexed_control_set[0][`URS_ACR_EXT_BIT]),
    .idx_rd_en (st_q.indexed_control_set[0][`URS_ACR_IDX_BIT]),
    .rd_sel    (rd_sel),
    .wr_sel    (wr_sel)
  );

  always_comb
  begin
    st_d         = st_q;
    st_d.rx_pop  = 1'b0;
    st_d.tx_load = 1'b0;
    if (wr_go)
    begin
      case (wr_sel)
        URS_SEL_XMIT:
        begin
          st_d.tx_load = 1'b1;
          st_d.tx_data = wdata;
        end
        URS_SEL_DIV_LO:  st_d.div_lo = wdata;
        URS_SEL_DIV_HI:  st_d.div_hi = wdata;
        URS_SEL_IER:     st_d.interrupt_enable = wdata;
        URS_SEL_FIFO:    st_d.fifo = wdata;
        URS_SEL_FORMAT:
        begin
          if (wdata == `URS_COMPAT_KEY)
          begin
            // key is not a format: keep the low bits so traffic is undisturbed
            st_d.fmt[`URS_FMT_DLAB_BIT] = 1'b1;
            st_d.compat = 1'b1;
          end
          else
          begin
            st_d.fmt    = wdata;
            st_d.compat = 1'b0;
          end
        end
        URS_SEL_MODEM:   st_d.modem = wdata;
        URS_SEL_SCRATCH: st_d.scratch = wdata;
        URS_SEL_FLOW:    st_d.flow = wdata;
        URS_SEL_XON1:    st_d.xchar[0] = wdata;
        URS_SEL_XON2:    st_d.xchar[1] = wdata;
        URS_SEL_XOFF1:   st_d.xchar[2] = wdata;
        URS_SEL_XOFF2:   st_d.xchar[3] = wdata;
        URS_SEL_INDEX:
        begin
          // offsets past the implemented set are dropped
          for (int i = 0; i < `URS_ICR_COUNT; i++)
          begin
            if (st_q.scratch == 8'(i))
              st_d.indexed_control_set[i] = wdata;
          end
        end
        default: st_d.tx_load = 1'b0;
      endcase
    end
    if (rd_go)
    begin
      case (rd_sel)
        URS_SEL_RECV:
        begin
          st_d.rdata  = rx_data;
          st_d.rx_pop = 1'b1;
        end
        URS_SEL_DIV_LO:  st_d.rdata = st_q.div_lo;
        URS_SEL_DIV_HI:  st_d.rdata = st_q.div_hi;
        URS_SEL_IER:     st_d.rdata = st_q.interrupt_enable;
        URS_SEL_IDENT:   st_d.rdata = ident_in;
        URS_SEL_FORMAT:  st_d.rdata = st_q.fmt;
        URS_SEL_MODEM:   st_d.rdata = st_q.modem;
        URS_SEL_LSTATE:  st_d.rdata = line_state_in;
        URS_SEL_MSTATE:  st_d.rdata = modem_state_in;
        URS_SEL_SCRATCH: st_d.rdata = st_q.scratch;
        URS_SEL_FLOW:    st_d.rdata = st_q.flow;
        URS_SEL_XON1:    st_d.rdata = st_q.xchar[0];
        URS_SEL_XON2:    st_d.rdata = st_q.xchar[1];
        URS_SEL_XOFF1:   st_d.rdata = st_q.xchar[2];
        URS_SEL_XOFF2:   st_d.rdata = st_q.xchar[3];
        URS_SEL_EXTSTAT: st_d.rdata = ext_status_in;
        URS_SEL_RXLVL:   st_d.rdata = rx_level_in;
        URS_SEL_TXLVL:   st_d.rdata = tx_level_in;
        URS_SEL_INDEX:
        begin
          st_d.rdata = `URS_RST_BYTE;
          for (int i = 0; i < `URS_ICR_COUNT; i++)
          begin
            if (st_q.scratch == 8'(i))
              st_d.rdata = st_q.indexed_control_set[i];
          end
        end
        default: st_d.rdata = `URS_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q         <= '0;
      st_q.fmt     <= `URS_RST_FORMAT;
      st_q.div_lo  <= `URS_RST_DIV_LOW;
      st_q.div_hi  <= `URS_RST_DIV_HIGH;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign rdata_q              = st_q.rdata;
  assign rx_pop_q             = st_q.rx_pop;
  assign tx_load_q            = st_q.tx_load;
  assign tx_data_q            = st_q.tx_data;
  assign divisor_q            = {st_q.div_hi, st_q.div_lo};
  // one format drives both directions; no per-direction copy exists
  assign frame_format_q       = st_q.fmt[6:0];
  assign tx_break_q           = st_q.fmt[6];
  assign interrupt_enable_q   = st_q.interrupt_enable;
  assign fifo_control_q       = st_q.fifo;
  assign modem_control_q      = st_q.modem;
  assign flow_control_q       = st_q.flow;
  assign additional_control_q = st_q.indexed_control_set[0];

  chk_dlab_low_read: assert property (
    @(posedge clock) disable iff (!rst_n)
    (rd_en && !wr_en && addr == 3'h0 && st_q.fmt[7])
    |=> (rdata_q == $past(st_q.div_lo)) && !rx_pop_q)
    else $error("divisor low byte not read at 000");

  chk_key_opens_compat: assert property (
    @(posedge clock) disable iff (!rst_n)
    (wr_en && addr == 3'h3 && wdata == 8'hbf) |=> st_q.compat)
    else $error("key write did not open compatibility set");

  chk_key_keeps_format: assert property (
    @(posedge clock) disable iff (!rst_n)
    (wr_en && addr == 3'h3 && wdata == 8'hbf)
    |=> st_q.fmt[7] && frame_format_q == $past(frame_format_q))
    else $error("key write disturbed the data format");

  chk_leave_compat: assert property (
    @(posedge clock) disable iff (!rst_n)
    (wr_en && addr == 3'h3 && wdata != 8'hbf)
    |=> !st_q.compat && frame_format_q == $past(wdata[6:0]))
    else $error("format write did not leave compatibility set");

  chk_divisor_join: assert property (
    @(posedge clock) disable iff (!rst_n)
    (wr_en && addr == 3'h1 && st_q.fmt[7])
    |=> divisor_q[15:8] == $past(wdata) && $stable(divisor_q[7:0]))
    else $error("divisor high byte not placed in bits 15 to 8");

  chk_xmit_load: assert property (
    @(posedge clock) disable iff (!rst_n)
    (wr_en && addr == 3'h0 && !st_q.fmt[7])
    |=> tx_load_q && tx_data_q == $past(wdata) && divisor_q == $past(divisor_q))
    else $error("transmit byte not loaded");

  chk_recv_pop: assert property (
    @(posedge clock) disable iff (!rst_n)
    (rd_en && !wr_en && addr == 3'h0 && !st_q.fmt[7])
    |=> rx_pop_q && rdata_q == $past(rx_data))
    else $error("receive byte not returned");

  chk_ext_level_read: assert property (
    @(posedge clock) disable iff (!rst_n)
    (rd_en && !wr_en && addr == 3'h3 && st_q.indexed_control_set[0][7] && !st_q.compat)
    |=> rdata_q == $past(rx_level_in))
    else $error("extended set not reached at 011");

  chk_index_read: assert property (
    @(posedge clock) disable iff (!rst_n)
    (rd_en && !wr_en && addr == 3'h5 && !st_q.compat && st_q.indexed_control_set[0][6]
     && st_q.scratch == 8'h00)
    |=> rdata_q == $past(additional_control_q))
    else $error("indexed control read failed");

  chk_scratch_index: assert property (
    @(posedge clock) disable iff (!rst_n)
    (wr_en && addr == 3'h5 && !st_q.compat && st_q.scratch == 8'h00)
    |=> additional_control_q == $past(wdata))
    else $error("scratch byte did not steer indexed write");

endmodule

// [urs_host_model.sv]
// host processor model: byte-wide register reads and writes
module urs_host_model
  import urs_pkg::*;
(
  // clock
  input  wire logic       clock,
  // register port
  output logic      [2:0] addr,
  output logic            wr_en,
  output logic            rd_en,
  output logic      [7:0] wdata,
  input  wire logic [7:0] rdata_q
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    addr  = 3'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    wdata = 8'h00;
  end

  // request held from a falling edge through the taking rising edge;
  // write data goes to its inverse once released so stale data never matches; addr is held
  // leaving the compatibility view is a plain line format write
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clock);
    addr  = a;
    wdata = d;
    wr_en = 1'b1;
    @(posedge clock);
    @(negedge clock);
    wr_en = 1'b0;
    wdata = ~d;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge clock);
    addr  = a;
    rd_en = 1'b1;
    @(posedge clock);
    @(negedge clock);
    rd_en = 1'b0;
    d     = rdata_q;
  endtask
endmodule

// [uart_register_select_bench.sv]
// self-checking bench of the register select
module uart_register_select_bench
  import urs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock;
  logic        rst_n;
  logic [2:0]  addr;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  wdata;
  logic [7:0]  rdata_q;
  logic [7:0]  rx_data;
  logic        rx_pop_q;
  logic        tx_load_q;
  logic [7:0]  tx_data_q;
  logic [15:0] divisor_q;
  logic [6:0]  frame_format_q;
  logic [7:0]  flow_control_q;
  logic [7:0]  additional_control_q;
  logic        tx_break_q;
  logic [7:0]  interrupt_enable_q;
  logic [7:0]  fifo_control_q;
  logic [7:0]  modem_control_q;
  logic [7:0]  rx_level;
  logic [7:0]  rv;
  int          n_mismatch;
  int          checks;

  urs_top dut_u (
    .clock(clock), .rst_n(rst_n), .addr(addr), .wr_en(wr_en),
    .rd_en(rd_en), .wdata(wdata), .rdata_q(rdata_q), .rx_data(rx_data),
    .rx_pop_q(rx_pop_q), .tx_load_q(tx_load_q), .tx_data_q(tx_data_q),
    .ident_in(8'h11), .line_state_in(8'h22), .modem_state_in(8'h33),
    .ext_status_in(8'h44), .rx_level_in(rx_level), .tx_level_in(8'h66),
    .divisor_q(divisor_q), .frame_format_q(frame_format_q),
    .tx_break_q(tx_break_q), .interrupt_enable_q(interrupt_enable_q),
    .fifo_control_q(fifo_control_q),
    .modem_control_q(modem_control_q), .flow_control_q(flow_control_q),
    .additional_control_q(additional_control_q)
  );

  urs_host_model host_u (
    .clock(clock), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
    .wdata(wdata), .rdata_q(rdata_q)
  );

  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // watchdog: the sequence needs well under 200 cycles
  initial
  begin
    #40000;
    n_mismatch++;
    results();
  end

  initial
  begin
    n_mismatch = 0;
    checks     = 0;
    rst_n      = 1'b0;
    rx_data    = 8'h5a;
    rx_level   = 8'h55;
    repeat (16) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    host_u.rd(3'h3, rv);
    chk("format reset", rv, 16'h0000);
    // divisor latch open
    host_u.wr(3'h3, 8'h83);
    host_u.wr(3'h0, 8'h34);
    chk("tx load", tx_load_q, 16'h0000);
    host_u.wr(3'h1, 8'h12);
    chk("divisor", divisor_q, 16'h1234);
    host_u.rd(3'h0, rv);
    chk("div low", rv, 16'h0034);
    host_u.rd(3'h1, rv);
    chk("div high", rv, 16'h0012);
    // compatibility key keeps the frame format bits
    host_u.wr(3'h3, 8'h03);
    host_u.wr(3'h3, 8'hbf);
    chk("frame", frame_format_q, 16'h0003);
    host_u.rd(3'h3, rv);
    chk("format key", rv, 16'h0083);
    host_u.wr(3'h2, 8'h5c);
    chk("flow out", flow_control_q, 16'h005c);
    host_u.rd(3'h2, rv);
    chk("flow rd", rv, 16'h005c);
    host_u.wr(3'h4, 8'h13);
    host_u.wr(3'h7, 8'h93);
    chk("modem kept", modem_control_q, 16'h0000);
    host_u.rd(3'h4, rv);
    chk("xon1", rv, 16'h0013);
    host_u.rd(3'h7, rv);
    chk("xoff2", rv, 16'h0093);
    host_u.wr(3'h3, 8'h03);
    host_u.rd(3'h2, rv);
    chk("ident", rv, 16'h0011);
    // normal view: control registers behind the base addresses
    host_u.wr(3'h1, 8'h0f);
    chk("ier", interrupt_enable_q, 16'h000f);
    host_u.wr(3'h2, 8'hc1);
    chk("fifo ctl", fifo_control_q, 16'h00c1);
    chk("flow kept", flow_control_q, 16'h005c);
    host_u.wr(3'h4, 8'h2b);
    chk("modem ctl", modem_control_q, 16'h002b);
    host_u.wr(3'h3, 8'h43);
    chk("break", tx_break_q, 16'h0001);
    host_u.wr(3'h3, 8'h03);
    chk("break off", tx_break_q, 16'h0000);
    // transmit and receive bytes at address 000
    host_u.wr(3'h0, 8'ha7);
    chk("tx pulse", tx_load_q, 16'h0001);
    chk("tx data", tx_data_q, 16'h00a7);
    host_u.rd(3'h0, rv);
    chk("rx byte", rv, 16'h005a);
    chk("rx pop", rx_pop_q, 16'h0001);
    // scratch offset 0 selects additional control through the window
    host_u.wr(3'h7, 8'h00);
    host_u.wr(3'h5, 8'hc0);
    chk("acr", additional_control_q, 16'h00c0);
    host_u.rd(3'h1, rv);
    chk("ext status", rv, 16'h0044);
    host_u.rd(3'h3, rv);
    chk("rx level", rv, 16'h0055);
    rx_level = 8'h56;
    host_u.rd(3'h3, rv);
    chk("rx level live", rv, 16'h0056);
    host_u.rd(3'h4, rv);
    chk("tx level", rv, 16'h0066);
    host_u.rd(3'h5, rv);
    chk("indexed", rv, 16'h00c0);
    host_u.wr(3'h7, 8'h9e);
    host_u.rd(3'h7, rv);
    chk("scratch", rv, 16'h009e);
    host_u.rd(3'h6, rv);
    chk("modem st", rv, 16'h0033);
    results();
  end
endmodule
